/* pkg/ebt_pkg.sv */
// Package with register offsets, field layouts, reset values and counts of the 8-bit timer/counter.
package ebt_pkg;

    localparam int unsigned CLK_HZ              = 50000000;
    localparam int unsigned CLK_PERIOD_NS       = 20;

    localparam logic [3:0]  ADDR_COUNT          = 4'h0;
    localparam logic [3:0]  ADDR_OPTION         = 4'h1;
    localparam logic [3:0]  ADDR_IRQ_STATUS     = 4'h2;
    localparam logic [3:0]  ADDR_IRQ_ENABLE     = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_CLEAR      = 4'h4;

    localparam int unsigned OPT_SRC_BIT         = 5;
    localparam int unsigned OPT_EDGE_BIT        = 4;
    localparam int unsigned OPT_BYPASS_BIT      = 3;
    localparam int unsigned OPT_RATE_LSB        = 0;
    localparam int unsigned RATE_W              = 3;

    localparam logic [7:0]  OPTION_RESET        = 8'hff;
    localparam logic [7:0]  COUNT_RESET         = 8'h00;
    localparam logic [7:0]  COUNT_MAX           = 8'hff;
    localparam logic [7:0]  PRESCALE_RESET      = 8'h00;
    localparam logic [7:0]  OPTION_MASK         = 8'h3f;

    localparam int unsigned IRQ_OVF_BIT         = 0;
    localparam int unsigned IRQ_EDGE_BIT        = 1;
    localparam int unsigned IRQ_W               = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET      = 2'h0;

    localparam logic [1:0]  WRITE_STALL_CYCLES  = 2'h2;
    localparam logic [1:0]  STALL_RESET         = 2'h0;
    localparam logic [7:0]  READ_ZERO           = 8'h00;

endpackage

/* design/ebt_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the external count pin.
`timescale 1ns/10ps

module ebt_pin_sync
    import ebt_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic CE,
    input  wire logic PIN,
    output logic      LEVEL
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ebt_sync_type;

    ebt_sync_type st_q;
    ebt_sync_type st_d;

    // The level only moves once the second and third stages agree.
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = PIN;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q <= '0;
        end
        else if (CE)
        begin
            st_q <= st_d;
        end
    end

    assign LEVEL = st_q.lvl;

endmodule

/* design/ebt_timer.sv */
// Top of the 8-bit timer/counter with prescaler, write stall, overflow flag and interrupt.
//
// How it works
// - An 8-bit count register is readable and writable, and a source bit picks timer or counter mode.
// - An 8-bit prescaler serves this counter alone and is shared with nothing else.
// - In timer mode without prescaler the count rises by one on every instruction cycle.
// - A cleared source bit selects timer mode fed by the instruction-cycle tick.
// - After each write to the count register the next two instruction cycles do not increment.
// - In counter mode without prescaler each qualifying edge on the external pin adds one.
// - A set source bit selects counter mode fed by the external pin.
// - The edge bit chooses rising (0) or falling (1) pin edges as the counting edge.
// - The overflow is offered as a gate source for the companion 16-bit timer.
// - A wrap from ff to 00 sets the overflow flag regardless of enable, and only software clears it.
// - With the prescaler assigned, the rate field divides the source by 2 up to 256.
// - A cleared bypass bit assigns the prescaler, a set one gives a 1:1 rate.
// - Any count write clears the hidden prescaler, which software cannot reach.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps

module ebt_timer
    import ebt_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic       INSTR_TICK,
    input  wire logic       EXTERNAL_COUNT_PIN,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    output logic            IRQ,
    output logic            OVERFLOW_GATE
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0]       count;
        logic [7:0]       option;
        logic [7:0]       prescale;
        logic [1:0]       stall;
        logic             pin_prev;
        logic             edge_seen;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] enable;
        logic [7:0]       rdata;
        logic             irq;
        logic             ovf_gate;
    } ebt_state_type;

    ebt_state_type st_q;
    ebt_state_type st_d;

    logic pin_level;

    ////////////////////////////////////////////////////////////////////////////////

    ebt_pin_sync u_pin_sync
    (
        .CLK   (CLK),
        .RST   (RST),
        .CE    (CE),
        .PIN   (EXTERNAL_COUNT_PIN),
        .LEVEL (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////////

    logic             src_sel;
    logic             edge_sel;
    logic             bypass;
    logic [2:0]       rate;
    logic             pin_edge;
    logic             src_pulse;
    logic             pre_tap;
    logic             inc_pulse;
    logic             count_wr;
    logic             overflow;
    logic [7:0]       pre_next;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clear_bits;

    always_comb
    begin
        st_d       = st_q;
        src_sel    = st_q.option[OPT_SRC_BIT];
        edge_sel   = st_q.option[OPT_EDGE_BIT];
        bypass     = st_q.option[OPT_BYPASS_BIT];
        rate       = st_q.option[OPT_RATE_LSB +: RATE_W];
        count_wr   = WR && (ADDR == ADDR_COUNT);
        clear_bits = '0;

        pin_edge = edge_sel ? (st_q.pin_prev && !pin_level) : (!st_q.pin_prev && pin_level);
        st_d.pin_prev  = pin_level;
        st_d.edge_seen = pin_edge;

        src_pulse = src_sel ? pin_edge : INSTR_TICK;

        pre_next  = st_q.prescale + 8'h01;
        pre_tap   = st_q.prescale[rate] && !pre_next[rate];
        inc_pulse = bypass ? src_pulse : (src_pulse && pre_tap);
        if (!bypass && src_pulse)
        begin
            st_d.prescale = pre_next;
        end

        overflow = 1'b0;
        if (INSTR_TICK && (st_q.stall != STALL_RESET))
        begin
            st_d.stall = st_q.stall - 2'h1;
        end

        if (count_wr)
        begin
            st_d.count    = WDATA;
            st_d.prescale = PRESCALE_RESET;
            st_d.stall    = WRITE_STALL_CYCLES;
        end
        else if (inc_pulse && (st_q.stall == STALL_RESET))
        begin
            st_d.count = st_q.count + 8'h01;
            overflow   = (st_q.count == COUNT_MAX);
        end

        st_d.ovf_gate = overflow;

        if (WR && (ADDR == ADDR_OPTION))
        begin
            st_d.option = WDATA & OPTION_MASK;
        end
        if (WR && (ADDR == ADDR_IRQ_ENABLE))
        begin
            st_d.enable = WDATA[IRQ_W-1:0];
        end
        if (WR && (ADDR == ADDR_IRQ_CLEAR))
        begin
            clear_bits = WDATA[IRQ_W-1:0];
        end

        events              = '0;
        events[IRQ_OVF_BIT]  = overflow;
        events[IRQ_EDGE_BIT] = st_q.edge_seen;
        st_d.status = (st_q.status & ~clear_bits) | events;
        st_d.irq    = |(st_d.status & st_d.enable);

        st_d.rdata = READ_ZERO;
        if (RD)
        begin
            case (ADDR)
                ADDR_COUNT:      st_d.rdata = st_q.count;
                ADDR_OPTION:     st_d.rdata = st_q.option;
                ADDR_IRQ_STATUS: st_d.rdata = {6'h00, st_q.status};
                ADDR_IRQ_ENABLE: st_d.rdata = {6'h00, st_q.enable};
                default:         st_d.rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q          <= '0;
            st_q.count    <= COUNT_RESET;
            st_q.option   <= OPTION_RESET & OPTION_MASK;
            st_q.prescale <= PRESCALE_RESET;
            st_q.stall    <= STALL_RESET;
            st_q.status   <= IRQ_RESET;
            st_q.enable   <= IRQ_RESET;
        end
        else if (CE)
        begin
            st_q <= st_d;
        end
    end

    assign RDATA         = st_q.rdata;
    assign IRQ           = st_q.irq;
    assign OVERFLOW_GATE = st_q.ovf_gate;

endmodule

/* verif/ebt_timer_sva.sv */
// Port checker for the 8-bit timer/counter.
`timescale 1ns/10ps

module ebt_timer_sva
    import ebt_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       IRQ,
    input wire logic       OVERFLOW_GATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata not idle");
    rd_hole_a: assert property (RD && ADDR >= ADDR_IRQ_CLEAR |=> RDATA == 8'h00) else $error("hole read");
    rd_option_a: assert property (RD && ADDR == ADDR_OPTION |=> RDATA[7:6] == 2'h0) else $error("option");
    rd_status_a: assert property (RD && ADDR == ADDR_IRQ_STATUS |=> RDATA[7:2] == 6'h00) else $error("sts");
    wr_hold_a: assert property ((WR && ADDR == ADDR_COUNT) ##2 (RD && ADDR == ADDR_COUNT)
        |=> RDATA == $past(WDATA, 3)) else $error("count write lost");
    gate_pulse_a: assert property (OVERFLOW_GATE |=> !OVERFLOW_GATE) else $error("gate too long");
    gate_nowr_a: assert property (OVERFLOW_GATE |-> !$past(WR && ADDR == ADDR_COUNT)) else $error("gate");
    irq_off_a: assert property (WR && ADDR == ADDR_IRQ_ENABLE && WDATA[1:0] == 2'h0 |=> !IRQ)
        else $error("irq while disabled");
endmodule

bind ebt_timer ebt_timer_sva chk (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .OVERFLOW_GATE);

/* verif/ebt_pulse_src.sv */
// Pulse source that toggles the external count pin.
`timescale 1ns/10ps

module ebt_pulse_src
(
    input  wire logic       CLK,
    input  wire logic       GO,
    input  wire logic [3:0] N,
    output logic            PIN,
    output logic            BUSY
);
    initial PIN = 1'b0;
    initial BUSY = 1'b0;
    always @(posedge CLK)
    begin
        if (GO)
        begin
            BUSY <= 1'b1;
            repeat (N)
            begin
                repeat (8) @(posedge CLK);
                PIN <= ~PIN;
            end
            repeat (8) @(posedge CLK);
            BUSY <= 1'b0;
        end
    end
endmodule

/* verif/ebt_timer_tb_top.sv */
// Self-checking bench for the 8-bit timer/counter.
`timescale 1ns/10ps

module ebt_timer_tb_top;
    import ebt_pkg::*;
    logic       clk = 0, rst = 1, ce = 1, tick = 0, wr = 0, rd = 0, go = 0, pin, busy, irq, gate, seen = 0;
    logic [3:0] addr = 4'h0, n = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    int         mismatches = 0, check_count = 0, cyc = 0;
    ebt_timer DUT (.CLK(clk), .RST(rst), .CE(ce), .INSTR_TICK(tick), .EXTERNAL_COUNT_PIN(pin), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .OVERFLOW_GATE(gate));
    ebt_pulse_src SRC (.CLK(clk), .GO(go), .N(n), .PIN(pin), .BUSY(busy));
    initial forever #10 clk = ~clk;
    always @(posedge clk)
    begin
        seen <= seen | (gate === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    task automatic ticks(input int k);
        repeat (k)
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask
    task automatic pulses(input logic [3:0] k);
        @(posedge clk);
        go <= 1'b1;
        n <= k;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 200 && busy === 1'b1; i++)
            @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rdc(4'(a), a == 1 ? 8'h3f : 8'h00);
        $display("test reset done");
        wrt(ADDR_OPTION, 8'h08);
        wrt(ADDR_COUNT, 8'h10);
        rdc(ADDR_COUNT, 8'h10);
        ticks(2);
        rdc(ADDR_COUNT, 8'h10);
        ticks(3);
        rdc(ADDR_COUNT, 8'h13);
        // Ticks while the clock enable is low must leave the count frozen.
        @(posedge clk);
        ce <= 1'b0;
        ticks(3);
        @(posedge clk);
        ce <= 1'b1;
        rdc(ADDR_COUNT, 8'h13);
        $display("test timer done");
        for (int r = 0; r < 8; r++)
        begin
            wrt(ADDR_OPTION, 8'(r));
            wrt(ADDR_COUNT, 8'h00);
            ticks(2 + (4 << r));
            rdc(ADDR_COUNT, 8'h02);
        end
        // A stale prescaler value of 3 at rate 1:4 would swallow the only tap; the write must clear it.
        wrt(ADDR_OPTION, 8'h01);
        wrt(ADDR_COUNT, 8'h00);
        ticks(3);
        wrt(ADDR_COUNT, 8'h00);
        ticks(4);
        rdc(ADDR_COUNT, 8'h01);
        $display("test prescaler done");
        wrt(ADDR_OPTION, 8'h08);
        wrt(ADDR_IRQ_ENABLE, 8'h01);
        rdc(ADDR_IRQ_ENABLE, 8'h01);
        wrt(ADDR_COUNT, COUNT_MAX);
        ticks(3);
        @(posedge clk);
        #1 chk("gate", {7'h00, seen}, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        wrt(ADDR_IRQ_ENABLE, 8'h00);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        rdc(ADDR_IRQ_STATUS, 8'h01);
        wrt(ADDR_IRQ_CLEAR, 8'h03);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        $display("test overflow done");
        wrt(ADDR_OPTION, 8'h28);
        wrt(ADDR_COUNT, 8'h00);
        ticks(2);
        pulses(4'h3);
        rdc(ADDR_COUNT, 8'h02);
        wrt(ADDR_OPTION, 8'h38);
        wrt(ADDR_COUNT, 8'h00);
        ticks(2);
        pulses(4'h3);
        rdc(ADDR_COUNT, 8'h02);
        rdc(ADDR_IRQ_STATUS, 8'h02);
        // Counter mode through the 1:2 prescaler: four toggles give two rising edges and one count.
        wrt(ADDR_OPTION, 8'h20);
        wrt(ADDR_COUNT, 8'h00);
        ticks(2);
        pulses(4'h4);
        rdc(ADDR_COUNT, 8'h01);
        wrt(ADDR_IRQ_ENABLE, 8'h02);
        #1 chk("irq", {7'h00, irq}, 8'h01);
        wrt(ADDR_IRQ_CLEAR, 8'h02);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        $display("test counter done");
        end_of_test();
    end
endmodule
